/* rtl/serial_baud_and_mode_control.sv */
// baud generator, mode registers and bit shifter of the serial interface
`timescale 1ns/1ns
// What this block does
// - baud select resets zero, low nibble zero
// - codes 0-7 divide by 2^(n+1), 8 external
// - internal rate is clock over 2^(n+1)*16
// - external rate is pin frequency over 16
// - external pin source only in async mode
// - all enables off: no transfer, pins general
// - serial mode bit7 enables three-wire mode
// - async byte after start bit, full duplex
// - serial mode bit1 picks three-wire clock
// - mode registers reset zero, bit writes allowed
// - baud select written as whole byte only
// - external path reaches 31.25 kbit/s
module serial_baud_and_mode_control
  import serial_baud_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // cpu register port
  input  wire logic [15:0] regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdata,
  // transmit byte stream from the cpu side
  input  wire logic        txValid,
  input  wire logic [7:0]  txData,
  output logic             txReady,
  // received byte stream to the cpu side
  output logic             rxValid,
  output logic      [7:0]  rxData,
  input  wire logic        rxReady,
  // serial pins
  input  wire logic        externalAsyncClockPin,
  input  wire logic        serialClockPinIn,
  output logic             serialClockPinOut,
  output logic             serialClockPinOe,
  input  wire logic        rxdPin,
  output logic             txdPin,
  output logic             txdPinOe,
  // status
  output logic             portFunctionMode,
  output logic             bitTick
);
  typedef enum logic [1:0] {
    SH_IDLE  = 2'b00,
    SH_START = 2'b01,
    SH_DATA  = 2'b10,
    SH_STOP  = 2'b11
  } shift_state_t;

  typedef struct packed {
    logic [7:0]   asyncMode;
    logic [7:0]   serialMode;
    logic [7:0]   baudSel;
    logic [7:0]   prescale;
    logic         extPinLast;
    logic         sckLast;
    logic [3:0]   tickCount;
    logic         bitPulse;
    logic         sckOut;
    logic         sckEdge;
    shift_state_t txState;
    logic [2:0]   txBitCnt;
    logic [7:0]   txShift;
    logic         txLine;
    shift_state_t rxState;
    logic [2:0]   rxBitCnt;
    logic [7:0]   rxShift;
    logic         rxPush;
    logic [7:0]   rxWord;
    logic [7:0]   rdata;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;
  serial_mode_t mode;
  logic [3:0]   sel;
  logic         srcTick;
  logic         extEdge;
  logic         sckRise;
  logic         sckFall;
  logic         bufReady;
  logic         msbFirst;

  byte_stream_if rxIn ();
  byte_stream_if rxOut ();

  // next shift register value in the chosen bit order
  function automatic logic [7:0] shiftIn(input logic [7:0] cur, input logic b,
                                         input logic msbF);
    return msbF ? {cur[6:0], b} : {b, cur[7:1]};
  endfunction

  // prescaler mask for source code c: bits c down to 0
  function automatic logic [7:0] lowMask(input logic [2:0] c);
    return 8'hff >> (3'd7 - c);
  endfunction

  // mode decode from the enable bits
  always_comb begin
    unique case ({st.serialMode[THREE_WIRE_ENABLE_BIT],
                  st.asyncMode[TRANSMITTER_ENABLE_BIT] | st.asyncMode[RECEIVER_ENABLE_BIT]})
      2'b00: mode = MODE_STOP;
      2'b01: mode = MODE_ASYNC;
      2'b10: mode = MODE_THREE;
      2'b11: mode = MODE_BAD;
    endcase
  end

  assign sel      = st.baudSel[SOURCE_SEL_LSB +: 4];
  assign msbFirst = !st.serialMode[BIT_ORDER_SELECT_BIT];
  assign extEdge  = externalAsyncClockPin && !st.extPinLast;
  assign sckRise  = serialClockPinIn && !st.sckLast;
  assign sckFall  = !serialClockPinIn && st.sckLast;

  // source tick: prescaler bits n down to 0 all set gives clock / 2^(n+1)
  always_comb begin
    srcTick = 1'b0;
    if (sel <= SEL_LAST_INTERNAL)
      srcTick = ((st.prescale & lowMask(sel[2:0])) == lowMask(sel[2:0]));
    else if (sel == SEL_EXTERNAL)
      srcTick = extEdge && (mode == MODE_ASYNC);
  end

  // register file, baud divider and shifters
  always_comb begin
    next_st          = st;
    next_st.bitPulse = 1'b0;
    next_st.sckEdge  = 1'b0;
    next_st.rxPush   = 1'b0;
    next_st.extPinLast = externalAsyncClockPin;
    next_st.sckLast  = serialClockPinIn;
    next_st.prescale = st.prescale + 8'd1;
    // register writes; baud select takes whole bytes only
    if (regWrite) begin
      unique case (regAddr)
        ASYNC_MODE_CONTROL_OFS:    next_st.asyncMode = regWdata & ASYNC_MODE_MASK;
        SERIAL_OPERATION_MODE_OFS: next_st.serialMode = regWdata & SERIAL_MODE_MASK;
        BAUD_CLOCK_SELECT_OFS:     next_st.baudSel = regWdata & BAUD_SEL_MASK;
        BIT_WRITE_OFS: begin
          // single-bit write: [7] target, [6:4] bit, [0] value
          if (!regWdata[7])
            next_st.asyncMode[regWdata[6:4]] = regWdata[0] & ASYNC_MODE_MASK[regWdata[6:4]];
          else
            next_st.serialMode[regWdata[6:4]] = regWdata[0] & SERIAL_MODE_MASK[regWdata[6:4]];
        end
        default: ;
      endcase
    end
    // bit clock: sixteen source ticks per bit; internal shift clock flips every eight
    if (mode == MODE_STOP) begin
      next_st.tickCount = '0;
    end else if (srcTick) begin
      next_st.tickCount = st.tickCount + 4'd1;
      if (sel != SEL_EXTERNAL && st.tickCount[2:0] == INT_TICKS_PER_BIT_M1[2:0]) begin
        next_st.sckOut  = !st.sckOut;
        next_st.sckEdge = 1'b1;
      end
      if (st.tickCount == TICKS_PER_BIT_M1) begin
        next_st.tickCount = '0;
        next_st.bitPulse  = 1'b1;
      end
    end
    // asynchronous transmitter: start, 8 data bits lsb first, stop
    // line rests high unless a transmit mode owns it
    if (mode != MODE_THREE
        && (mode != MODE_ASYNC || !st.asyncMode[TRANSMITTER_ENABLE_BIT])) begin
      next_st.txState = SH_IDLE;
      next_st.txLine  = 1'b1;
    end
    if (mode == MODE_ASYNC && st.asyncMode[TRANSMITTER_ENABLE_BIT]) begin
      unique case (st.txState)
        SH_IDLE: if (txValid) begin
          next_st.txShift = txData;
          next_st.txState = SH_START;
        end
        SH_START: if (st.bitPulse) begin
          next_st.txLine   = 1'b0;
          next_st.txBitCnt = '0;
          next_st.txState  = SH_DATA;
        end
        SH_DATA: if (st.bitPulse) begin
          next_st.txLine   = st.txShift[0];
          next_st.txShift  = {1'b0, st.txShift[7:1]};
          next_st.txBitCnt = st.txBitCnt + 3'd1;
          if (st.txBitCnt == 3'd7) next_st.txState = SH_STOP;
        end
        SH_STOP: if (st.bitPulse) begin
          next_st.txLine  = 1'b1;
          next_st.txState = SH_IDLE;
        end
      endcase
    end
    // three-wire shifter: out on falling, in on rising edge of the shift clock
    if (mode == MODE_THREE) begin
      unique case (st.txState)
        SH_IDLE: if (txValid) begin
          next_st.txShift  = txData;
          next_st.txBitCnt = '0;
          next_st.txLine   = msbFirst ? txData[7] : txData[0];
          next_st.txState  = SH_DATA;
        end
        SH_DATA: begin
          if (st.serialMode[CLOCK_SOURCE_BIT] ? (st.sckEdge && !st.sckOut)
                                             : sckRise) begin
            next_st.rxShift  = shiftIn(st.rxShift, rxdPin, msbFirst);
            next_st.txBitCnt = st.txBitCnt + 3'd1;
            if (st.txBitCnt == 3'd7) begin
              next_st.rxWord  = shiftIn(st.rxShift, rxdPin, msbFirst);
              next_st.rxPush  = 1'b1;
              next_st.txState = SH_IDLE;
            end
          end
          if (st.serialMode[CLOCK_SOURCE_BIT] ? (st.sckEdge && st.sckOut)
                                             : sckFall) begin
            next_st.txShift = msbFirst ? {st.txShift[6:0], 1'b0} : {1'b0, st.txShift[7:1]};
            next_st.txLine  = msbFirst ? st.txShift[6] : st.txShift[1];
          end
        end
        default: next_st.txState = SH_IDLE;
      endcase
    end
    // asynchronous receiver sampled on each bit tick
    if (mode != MODE_ASYNC || !st.asyncMode[RECEIVER_ENABLE_BIT]) begin
      next_st.rxState = SH_IDLE;
    end else begin
      unique case (st.rxState)
        // start seen on one tick; the next tick samples bit 0
        SH_IDLE: if (st.bitPulse && !rxdPin) begin
          next_st.rxBitCnt = '0;
          next_st.rxState  = SH_DATA;
        end
        SH_START: next_st.rxState = SH_IDLE;
        SH_DATA: if (st.bitPulse) begin
          next_st.rxShift  = {rxdPin, st.rxShift[7:1]};
          next_st.rxBitCnt = st.rxBitCnt + 3'd1;
          if (st.rxBitCnt == 3'd7) next_st.rxState = SH_STOP;
        end
        SH_STOP: if (st.bitPulse) begin
          next_st.rxWord  = st.rxShift;
          next_st.rxPush  = rxdPin && bufReady;
          next_st.rxState = SH_IDLE;
        end
      endcase
    end
    // read data stand the cycle after the strobe
    next_st.rdata = 8'h00;
    if (regRead) begin
      unique case (regAddr)
        ASYNC_MODE_CONTROL_OFS:    next_st.rdata = st.asyncMode;
        SERIAL_OPERATION_MODE_OFS: next_st.rdata = st.serialMode;
        BAUD_CLOCK_SELECT_OFS:     next_st.rdata = st.baudSel;
        default:                   next_st.rdata = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st            <= '0;
      st.txLine     <= 1'b1;
      st.sckLast    <= 1'b1; // shift clock pin idles high
      st.asyncMode  <= ASYNC_MODE_CONTROL_RST;
      st.serialMode <= SERIAL_OPERATION_MODE_RST;
      st.baudSel    <= BAUD_CLOCK_SELECT_RST;
    end else begin
      st <= next_st;
    end
  end

  // received bytes pass through the two-entry buffer
  assign rxIn.valid  = st.rxPush;
  assign rxIn.data   = st.rxWord;
  assign bufReady    = rxIn.ready;
  assign rxValid     = rxOut.valid;
  assign rxData      = rxOut.data;
  assign rxOut.ready = rxReady;

  skid_buffer rxBuf (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .inPort  (rxIn),
    .outPort (rxOut)
  );

  // outputs and pin drive; enables low while driving
  assign regRdata          = st.rdata;
  assign txReady           = (st.txState == SH_IDLE) && (mode == MODE_ASYNC || mode == MODE_THREE)
                             && (mode == MODE_THREE || st.asyncMode[TRANSMITTER_ENABLE_BIT]);
  assign txdPin            = st.txLine;
  assign txdPinOe          = !((mode == MODE_ASYNC && st.asyncMode[TRANSMITTER_ENABLE_BIT])
                               || mode == MODE_THREE);
  assign serialClockPinOut = !st.sckOut;
  assign serialClockPinOe  = !(mode == MODE_THREE && st.serialMode[CLOCK_SOURCE_BIT]);
  assign portFunctionMode  = (mode == MODE_STOP);
  assign bitTick           = st.bitPulse;
endmodule

/* pkg/serial_baud_pkg.sv */
// package: register map, fields, reset values and timing figures of the serial baud block
package serial_baud_pkg;
  // register offsets on the cpu port
  localparam logic [15:0] ASYNC_MODE_CONTROL_OFS    = 16'hff70;
  localparam logic [15:0] SERIAL_OPERATION_MODE_OFS = 16'hff72;
  localparam logic [15:0] BAUD_CLOCK_SELECT_OFS     = 16'hff73;
  localparam logic [15:0] BIT_WRITE_OFS             = 16'hff7f;
  // reset values
  localparam logic [7:0] ASYNC_MODE_CONTROL_RST    = 8'h00;
  localparam logic [7:0] SERIAL_OPERATION_MODE_RST = 8'h00;
  localparam logic [7:0] BAUD_CLOCK_SELECT_RST     = 8'h00;
  // field positions
  localparam int TRANSMITTER_ENABLE_BIT  = 7;
  localparam int RECEIVER_ENABLE_BIT     = 6;
  localparam int THREE_WIRE_ENABLE_BIT   = 7;
  localparam int BIT_ORDER_SELECT_BIT    = 2;
  localparam int CLOCK_SOURCE_BIT        = 1;
  localparam int SOURCE_SEL_LSB          = 4;
  // writable masks: reserved bits are held at zero
  localparam logic [7:0] ASYNC_MODE_MASK  = 8'hfc;
  localparam logic [7:0] SERIAL_MODE_MASK = 8'h86;
  localparam logic [7:0] BAUD_SEL_MASK    = 8'hf0;
  // source selector codes
  localparam logic [3:0] SEL_LAST_INTERNAL = 4'h7;
  localparam logic [3:0] SEL_EXTERNAL      = 4'h8;
  // bit clock: one bit (or one shift clock half period) is this many source ticks plus one
  localparam logic [3:0] TICKS_PER_BIT_M1  = 4'hf;
  localparam logic [3:0] INT_TICKS_PER_BIT_M1 = 4'h7;
  // system clock figures
  localparam int REF_CLK_HZ = 25_000_000;
  localparam int REF_CLK_NS = 1_000_000_000 / REF_CLK_HZ;
  // mode encoding
  typedef enum logic [1:0] {
    MODE_STOP  = 2'b00,
    MODE_ASYNC = 2'b01,
    MODE_THREE = 2'b10,
    MODE_BAD   = 2'b11
  } serial_mode_t;
endpackage

/* pkg/byte_stream_if.sv */
// interface: one valid/ready byte stream between the block and its buffer
`timescale 1ns/1ns
interface byte_stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

/* rtl/skid_buffer.sv */
// two-entry byte buffer with valid/ready on both sides
`timescale 1ns/1ns
module skid_buffer (
  // clock and reset
  input  wire logic   ref_clk,
  input  wire logic   rstn,
  // streams
  byte_stream_if.sink   inPort,
  byte_stream_if.source outPort
);
  typedef struct packed {
    logic [7:0] slot0;
    logic [7:0] slot1;
    logic [1:0] count;
  } buf_state_t;

  buf_state_t st;
  buf_state_t next_st;
  logic       push;
  logic       pop;

  // handshakes and outputs
  assign inPort.ready  = (st.count != 2'd2);
  assign outPort.valid = (st.count != 2'd0);
  assign outPort.data  = st.slot0;
  assign push          = inPort.valid && inPort.ready;
  assign pop           = outPort.valid && outPort.ready;

  // slot0 is the head; slot1 holds the second word
  always_comb begin
    next_st = st;
    unique case ({push, pop})
      2'b10: begin
        if (st.count == 2'd0) next_st.slot0 = inPort.data;
        else next_st.slot1 = inPort.data;
        next_st.count = st.count + 2'd1;
      end
      2'b01: begin
        next_st.slot0 = st.slot1;
        next_st.count = st.count - 2'd1;
      end
      2'b11: begin
        if (st.count == 2'd1) next_st.slot0 = inPort.data;
        else begin
          next_st.slot0 = st.slot1;
          next_st.slot1 = inPort.data;
        end
      end
      2'b00: next_st = st;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) st <= '0;
    else st <= next_st;
  end
endmodule

/* verification/serial_baud_assertions.sv */
// checker: port-level properties of the serial baud block
`timescale 1ns/1ns
module serial_baud_checker
  import serial_baud_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  // register port
  input wire logic [15:0] regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regRdata,
  // stream, pins and status
  input wire logic        txValid,
  input wire logic        txReady,
  input wire logic        txdPinOe,
  input wire logic        serialClockPinOe,
  input wire logic        portFunctionMode,
  input wire logic        bitTick
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // register read-backs
  property p_baud_pad;
    regRead && regAddr == BAUD_CLOCK_SELECT_OFS |=> regRdata[3:0] == 4'h0;
  endproperty
  a_baud_pad: assert property (p_baud_pad) else $error("baud low bits set");
  property p_async_pad;
    regRead && regAddr == ASYNC_MODE_CONTROL_OFS |=> regRdata[1:0] == 2'h0;
  endproperty
  a_async_pad: assert property (p_async_pad) else $error("async low bits set");
  // port function when all enables are off
  property p_port_pins;
    portFunctionMode [*3] |-> txdPinOe && serialClockPinOe;
  endproperty
  a_port_pins: assert property (p_port_pins) else $error("pin driven when idle");
  property p_port_quiet;
    portFunctionMode [*3] |-> !bitTick;
  endproperty
  a_port_quiet: assert property (p_port_quiet) else $error("tick when stopped");
  // three-wire enable and clock source
  property p_three_on;
    regWrite && regAddr == SERIAL_OPERATION_MODE_OFS && regWdata[7] |=> !portFunctionMode;
  endproperty
  a_three_on: assert property (p_three_on) else $error("three-wire not on");
  property p_sck_int;
    regWrite && regAddr == SERIAL_OPERATION_MODE_OFS && regWdata == 8'h82 |=> !serialClockPinOe;
  endproperty
  a_sck_int: assert property (p_sck_int) else $error("clock pin not driven");
  property p_sck_ext;
    regWrite && regAddr == SERIAL_OPERATION_MODE_OFS && regWdata == 8'h80 |=> serialClockPinOe;
  endproperty
  a_sck_ext: assert property (p_sck_ext) else $error("clock pin driven");
  // byte take and bit tick shape
  property p_tx_take;
    txValid && txReady |=> !txReady;
  endproperty
  a_tx_take: assert property (p_tx_take) else $error("tx still ready");
  property p_tick_pulse;
    bitTick |=> !bitTick [*3];
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick too close");
endmodule
bind serial_baud_and_mode_control serial_baud_checker chk (.ref_clk, .rstn, .regAddr,
  .regWdata, .regWrite, .regRead, .regRdata, .txValid, .txReady, .txdPinOe,
  .serialClockPinOe, .portFunctionMode, .bitTick);

/* verification/serial_peer.sv */
// partner: remote serial peer on the async lines and external baud pin
`timescale 1ns/1ns
module serial_peer (
  // clock
  input  wire logic ref_clk,
  // lines
  input  wire logic txLine,
  output logic      rxdLine,
  output logic      extClk,
  output logic      sckLine
);
  int         extHalf  = 0;
  int         extCnt   = 0;
  int         rxPer    = 64;
  int         gotCount = 0;
  logic [7:0] lastByte;
  // idle: data high, shift clock still
  initial begin
    rxdLine = 1'b1;
    extClk  = 1'b0;
    sckLine = 1'b1;
  end
  // external baud source, only while a half period is set
  always @(posedge ref_clk) begin
    if (extHalf > 0) begin
      extCnt = extCnt + 1;
      if (extCnt >= extHalf) begin
        extCnt = 0;
        extClk <= ~extClk;
      end
    end
  end
  // one frame: start, eight bits lsb first, stop
  task automatic sendByte(input logic [7:0] b, input int per);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxdLine <= f[i];
      repeat (per) @(posedge ref_clk);
    end
  endtask
  // frames from the device, sampled mid-bit
  always @(negedge txLine) begin
    repeat (rxPer + rxPer / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      lastByte[i] = txLine;
      repeat (rxPer) @(posedge ref_clk);
    end
    gotCount++;
  end
endmodule

/* verification/serial_baud_and_mode_control_test.sv */
// testbench: registers, rates, byte traffic and modes of the serial block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module serial_baud_and_mode_control_test;
  import serial_baud_pkg::*;
  logic        ref_clk  = 1'b0;
  logic        rstn     = 1'b0;
  logic [15:0] regAddr  = 16'h0000;
  logic [7:0]  regWdata = 8'h00;
  logic        regWrite = 1'b0;
  logic        regRead  = 1'b0;
  logic        txValid  = 1'b0;
  logic [7:0]  txData   = 8'h00;
  logic        rxReady  = 1'b0;
  logic [7:0]  regRdata, rxData;
  logic        txReady, rxValid, extClk, peerSck, rxdLine, sckOut, serialClockPinOe;
  logic        txdPin, txdPinOe, portFunctionMode, bitTick;
  int          bad_count = 0;
  int          cmp_count = 0;
  // pulled-up data line and shared clock pin
  wire         txLine  = txdPinOe ? 1'b1 : txdPin;
  wire         sckLine = serialClockPinOe ? peerSck : sckOut;
  serial_baud_and_mode_control uut (.ref_clk, .rstn, .regAddr, .regWdata, .regWrite,
    .regRead, .regRdata, .txValid, .txData, .txReady, .rxValid, .rxData, .rxReady,
    .externalAsyncClockPin(extClk), .serialClockPinIn(sckLine), .serialClockPinOut(sckOut),
    .serialClockPinOe, .rxdPin(rxdLine), .txdPin, .txdPinOe, .portFunctionMode, .bitTick);
  serial_peer peer (.ref_clk, .txLine, .rxdLine, .extClk, .sckLine(peerSck));
  initial forever #20 ref_clk = ~ref_clk;
  // register port cycles
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 `CHK("regRdata", e, regRdata)
  endtask
  // cycles between two bit ticks
  task automatic tick_gap(output int n);
    n = 0;
    for (int k = 0; k < 5000 && bitTick !== 1'b1; k++) @(negedge ref_clk);
    @(negedge ref_clk);
    while (bitTick !== 1'b1 && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
    n++;
  endtask
  task automatic t_regs;
    rdchk(BAUD_CLOCK_SELECT_OFS, 8'h00);
    rdchk(SERIAL_OPERATION_MODE_OFS, 8'h00);
    rdchk(ASYNC_MODE_CONTROL_OFS, 8'h00);
    wr(BIT_WRITE_OFS, 8'hf1);
    rdchk(SERIAL_OPERATION_MODE_OFS, 8'h80);
    wr(SERIAL_OPERATION_MODE_OFS, 8'hff);
    rdchk(SERIAL_OPERATION_MODE_OFS, 8'h86);
    wr(SERIAL_OPERATION_MODE_OFS, 8'h00);
    wr(BIT_WRITE_OFS, 8'h71);
    rdchk(ASYNC_MODE_CONTROL_OFS, 8'h80);
    wr(ASYNC_MODE_CONTROL_OFS, 8'hff);
    wr(BAUD_CLOCK_SELECT_OFS, 8'h7f);
    wr(16'hff71, 8'hff);
    rdchk(ASYNC_MODE_CONTROL_OFS, 8'hfc);
    rdchk(BAUD_CLOCK_SELECT_OFS, 8'h70);
    rdchk(16'hff71, 8'h00);
  endtask
  task automatic t_rate;
    int g;
    wr(ASYNC_MODE_CONTROL_OFS, 8'h80);
    for (int c = 1; c <= 3; c++) begin
      wr(BAUD_CLOCK_SELECT_OFS, 8'(c << 4));
      tick_gap(g);
      tick_gap(g);
      `CHK("bitTick gap", 32 << c, g)
    end
    peer.extHalf = 25;
    wr(BAUD_CLOCK_SELECT_OFS, {SEL_EXTERNAL, 4'h0});
    tick_gap(g);
    tick_gap(g);
    `CHK("ext gap", 800, g)
    peer.extHalf = 0;
    wr(BAUD_CLOCK_SELECT_OFS, 8'h10);
  endtask
  task automatic t_tx;
    int k;
    k = peer.gotCount;
    @(posedge ref_clk);
    txValid <= 1'b1;
    txData  <= 8'ha5;
    for (int i = 0; i < 500 && txReady !== 1'b1; i++) @(negedge ref_clk);
    @(posedge ref_clk);
    txValid <= 1'b0;
    @(negedge ref_clk);
    `CHK("txReady", 1'b0, txReady)
    for (int i = 0; i < 2000 && peer.gotCount == k; i++) @(negedge ref_clk);
    `CHK("txdPinOe", 1'b0, txdPinOe)
    `CHK("peer byte", 8'ha5, peer.lastByte)
  endtask
  // three words while the reader stalls: third one is dropped
  task automatic t_rx;
    wr(ASYNC_MODE_CONTROL_OFS, 8'h40);
    for (int k = 0; k < 500 && bitTick !== 1'b1; k++) @(negedge ref_clk);
    repeat (32) @(posedge ref_clk);
    for (int i = 1; i <= 3; i++) peer.sendByte(8'(8'h11 * i), 64);
    repeat (4) @(negedge ref_clk);
    for (int i = 0; i < 3; i++) begin
      `CHK("rxValid", i < 2, rxValid)
      if (i < 2) `CHK("rxData", 8'(8'h11 * (i + 1)), rxData)
      @(posedge ref_clk);
      rxReady <= 1'b1;
      @(posedge ref_clk);
      rxReady <= 1'b0;
      repeat (3) @(negedge ref_clk);
    end
  endtask
  // three-wire, internal clock: first bit by bit order, eight shift clock rises
  task automatic t_three;
    int   n;
    logic last;
    wr(ASYNC_MODE_CONTROL_OFS, 8'h00);
    for (int d = 0; d < 2; d++) begin
      wr(SERIAL_OPERATION_MODE_OFS, d[0] ? 8'h86 : 8'h82);
      @(posedge ref_clk);
      txValid <= 1'b1;
      txData  <= 8'h01;
      @(negedge ref_clk);
      last = sckOut;
      @(posedge ref_clk);
      txValid <= 1'b0;
      @(negedge ref_clk);
      `CHK("txdPin first bit", d[0], txdPin)
      n = 0;
      for (int i = 0; i < 1000 && txReady !== 1'b1; i++) begin
        if (sckOut && !last) n++;
        last = sckOut;
        @(negedge ref_clk);
      end
      `CHK("shift clock rises", 8, n)
      repeat (2) @(negedge ref_clk);
      `CHK("three-wire rxData", 8'hff, rxData)
      @(posedge ref_clk);
      rxReady <= 1'b1;
      @(posedge ref_clk);
      rxReady <= 1'b0;
    end
    wr(SERIAL_OPERATION_MODE_OFS, 8'h00);
  endtask
  task automatic t_mode;
    wr(ASYNC_MODE_CONTROL_OFS, 8'h00);
    wr(SERIAL_OPERATION_MODE_OFS, 8'h82);
    @(negedge ref_clk);
    `CHK("portFunctionMode", 1'b0, portFunctionMode)
    `CHK("serialClockPinOe", 1'b0, serialClockPinOe)
    wr(SERIAL_OPERATION_MODE_OFS, 8'h80);
    @(negedge ref_clk);
    `CHK("serialClockPinOe", 1'b1, serialClockPinOe)
    wr(SERIAL_OPERATION_MODE_OFS, 8'h00);
    repeat (4) @(negedge ref_clk);
    `CHK("portFunctionMode", 1'b1, portFunctionMode)
    `CHK("txdPinOe", 1'b1, txdPinOe)
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // main sequence after 20 reset cycles
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    t_regs;
    t_rate;
    t_tx;
    t_rx;
    t_three;
    t_mode;
    final_report;
  end
  // watchdog
  initial begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    final_report;
  end
endmodule
